// file: hdl/mci_consts.svh
// Constants of the module command and input mask block.
// Assumes an APB slave with 32-bit data and word-aligned registers.
`ifndef MCI_CONSTS_SVH
`define MCI_CONSTS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define MCI_ADDR_MASK 12'h000
`define MCI_ADDR_HOMING 12'h004
`define MCI_ADDR_COMMAND 12'h008
`define MCI_ADDR_CONTROL 12'h00C
`define MCI_ADDR_STATUS 12'h010

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MCI_LOW_LSB 0
`define MCI_HIGH_LSB 8
`define MCI_INV_LSB 16
`define MCI_MASK_USED 32'h000F0F0F
`define MCI_HOMING_USED 32'h000000FF
`define MCI_MOTOR_SET_LSB 24

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MCI_MASK_RST 32'h00000000
`define MCI_HOMING_RST 8'h00
`define MCI_CONTROL_RST 32'h00000000

// ----------------------------------------
// Command codes
// ----------------------------------------
`define MCI_CMD_NOP 32'h00000000
`define MCI_CMD_RESET 32'h00000001
`define MCI_CMD_SAVE 32'h00000010
`define MCI_CMD_IDENT 32'h00000011
`define MCI_CMD_DEFAULTS 32'h00000012
`define MCI_CMD_SYNC_ON 32'h00000013
`define MCI_CMD_SYNC_OFF 32'h00000014
`define MCI_CMD_REINIT 32'h00000015
`define MCI_CMD_CYC_STOP 32'h00000016
`define MCI_CMD_CYC_GO 32'h00000017
`define MCI_CMD_SYNC_RESET 32'h00000101
`define MCI_CMD_MOTOR_SAVE 32'h00000110

// ----------------------------------------
// Timing
// ----------------------------------------
`define MCI_CLK_HZ 50000000
`define MCI_IDENT_S 120
`define MCI_SEC_CYCLES (`MCI_CLK_HZ)
`define MCI_BLINK_CYCLES (`MCI_CLK_HZ / 4)

`endif

// file: hdl/mci_pkg.sv
// Types of the module command and input mask block.
// Assumes the constants header is included by the design.
package mci_pkg;

   typedef struct packed {
      logic [3:0] invert;
      logic [3:0] high_sel;
      logic [3:0] low_sel;
   } mci_mask_t;

   typedef struct packed {
      logic module_reset;
      logic flash_save;
      logic factory_restore;
      logic cyclic_reinit;
      logic motor_reset;
      logic motor_save_resync;
   } mci_pulse_t;

   typedef struct packed {
      logic valid;
      logic [31:0] code;
   } mci_fwd_t;

endpackage : mci_pkg

// file: hdl/mci_core.sv
// Register logic of the motor interface module: limit input mask,
// default homing method and command interpreter behind an APB slave.
// Assumes inputs synchronous to ref_clk; actions beyond this block are
// taken by the logic that receives the one-cycle pulses.
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "mci_consts.svh"

module mci_core
   import mci_pkg::*;
#(
   parameter int SEC_CYCLES = `MCI_SEC_CYCLES,
   parameter int BLINK_CYCLES = `MCI_BLINK_CYCLES,
   parameter bit MOTOR_FAMILY_A = 1'b1
)
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] digital_input_lines,
   input wire logic drive_profile_on,
   input wire logic bus_sync_pulse,
   input wire logic [7:0] stored_homing,
   input wire logic stored_valid,
   output logic neg_limit,
   output logic pos_limit,
   output logic [7:0] active_homing,
   output logic digital_output_one,
   output logic power_led,
   output logic cyclic_write_on,
   output mci_pulse_t action,
   output mci_fwd_t motor_cmd
);

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   logic wr_en;
   logic rd_en;
   logic hit;
   logic [31:0] limit_input_mask;
   logic [7:0] default_homing_select;
   logic [31:0] ctrl;
   logic [31:0] last_code;
   logic sync_route;
   logic ident_on;
   logic power_up_done;
   logic [$clog2(SEC_CYCLES+1)-1:0] sec_cnt;
   logic [6:0] ident_secs;
   logic [$clog2(BLINK_CYCLES+1)-1:0] blink_cnt;
   logic blink;
   logic [31:0] next_prdata;
   mci_mask_t mask;

   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & penable & ~pwrite;
   assign hit = (paddr == `MCI_ADDR_MASK) || (paddr == `MCI_ADDR_HOMING)
      || (paddr == `MCI_ADDR_COMMAND) || (paddr == `MCI_ADDR_CONTROL)
      || (paddr == `MCI_ADDR_STATUS);
   assign pready = 1'b1;
   // Unmapped, reading write-only, or writing status gives an error
   assign pslverr = psel & penable & (~hit
      | (~pwrite & (paddr == `MCI_ADDR_COMMAND))
      | (pwrite & (paddr == `MCI_ADDR_STATUS)));

   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (rst || action.factory_restore)
      begin
         limit_input_mask <= `MCI_MASK_RST;
         ctrl <= `MCI_CONTROL_RST;
      end
      else if (wr_en && paddr == `MCI_ADDR_MASK)
      begin
         limit_input_mask <= merge(limit_input_mask, pwdata, pstrb)
            & `MCI_MASK_USED;
      end
      else if (wr_en && paddr == `MCI_ADDR_CONTROL)
      begin
         ctrl <= merge(ctrl, pwdata, pstrb);
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst || action.factory_restore)
      begin
         default_homing_select <= `MCI_HOMING_RST;
      end
      else if (wr_en && paddr == `MCI_ADDR_HOMING && pstrb[0])
      begin
         default_homing_select <= pwdata[7:0];
      end
   end

   // Power-up load of the homing method from flash contents
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         active_homing <= 8'h00;
         power_up_done <= 1'b0;
      end
      else if (!power_up_done && stored_valid)
      begin
         active_homing <= stored_homing;
         power_up_done <= 1'b1;
      end
   end

   // ----------------------------------------
   // Limit switch mapping
   // ----------------------------------------
   assign mask = mci_mask_t'({limit_input_mask[19:16],
      limit_input_mask[11:8], limit_input_mask[3:0]});

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         neg_limit <= 1'b0;
         pos_limit <= 1'b0;
      end
      else
      begin
         // Ignored unless the standard drive profile is chosen
         neg_limit <= drive_profile_on
            & |(mask.low_sel & (digital_input_lines ^ mask.invert));
         pos_limit <= drive_profile_on
            & |(mask.high_sel & (digital_input_lines ^ mask.invert));
      end
   end

   // ----------------------------------------
   // Command interpreter
   // ----------------------------------------
   logic cmd_new;
   assign cmd_new = wr_en && paddr == `MCI_ADDR_COMMAND
      && pwdata != last_code;

   // A command register with partial strobes still takes the whole code
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         last_code <= `MCI_CMD_NOP;
      end
      else if (wr_en && paddr == `MCI_ADDR_COMMAND)
      begin
         last_code <= pwdata;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         action <= '0;
         motor_cmd <= '0;
      end
      else
      begin
         action <= '0;
         motor_cmd.valid <= 1'b0;
         if (cmd_new)
         begin
            case (pwdata)
               `MCI_CMD_RESET: action.module_reset <= 1'b1;
               `MCI_CMD_SAVE: action.flash_save <= 1'b1;
               `MCI_CMD_DEFAULTS: action.factory_restore <= 1'b1;
               `MCI_CMD_REINIT:
                  action.cyclic_reinit <= MOTOR_FAMILY_A;
               `MCI_CMD_SYNC_RESET: action.motor_reset <= 1'b1;
               `MCI_CMD_MOTOR_SAVE:
                  action.motor_save_resync <= 1'b1;
               default:
               begin
                  // Codes in the motor sets go to the motor controller
                  if (pwdata[31:`MCI_MOTOR_SET_LSB] != 8'h00)
                  begin
                     motor_cmd.valid <= 1'b1;
                     motor_cmd.code <= pwdata;
                  end
               end
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst || action.factory_restore)
      begin
         sync_route <= 1'b0;
         cyclic_write_on <= 1'b1;
      end
      else if (cmd_new && MOTOR_FAMILY_A)
      begin
         case (pwdata)
            `MCI_CMD_SYNC_ON: sync_route <= 1'b1;
            `MCI_CMD_SYNC_OFF: sync_route <= 1'b0;
            `MCI_CMD_CYC_STOP: cyclic_write_on <= 1'b0;
            `MCI_CMD_CYC_GO: cyclic_write_on <= 1'b1;
            default: sync_route <= sync_route;
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         digital_output_one <= 1'b0;
      end
      else
      begin
         digital_output_one <= sync_route & bus_sync_pulse;
      end
   end

   // ----------------------------------------
   // Identification blink
   // ----------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         ident_on <= 1'b0;
         ident_secs <= '0;
         sec_cnt <= '0;
      end
      else if (cmd_new && pwdata == `MCI_CMD_IDENT && MOTOR_FAMILY_A)
      begin
         ident_on <= 1'b1;
         ident_secs <= 7'(`MCI_IDENT_S);
         sec_cnt <= '0;
      end
      else if (ident_on)
      begin
         if (sec_cnt == ($bits(sec_cnt))'(SEC_CYCLES - 1))
         begin
            sec_cnt <= '0;
            ident_secs <= ident_secs - 7'h01;
            if (ident_secs == 7'h01)
            begin
               ident_on <= 1'b0;
            end
         end
         else
         begin
            sec_cnt <= sec_cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst || !ident_on)
      begin
         blink_cnt <= '0;
         blink <= 1'b0;
      end
      else if (blink_cnt == ($bits(blink_cnt))'(BLINK_CYCLES - 1))
      begin
         blink_cnt <= '0;
         blink <= ~blink;
      end
      else
      begin
         blink_cnt <= blink_cnt + 1'b1;
      end
   end

   // Power LED lit steadily outside identification
   assign power_led = ident_on ? ~blink : 1'b1;

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   always_comb
   begin
      next_prdata = 32'h00000000;
      case (paddr)
         `MCI_ADDR_MASK: next_prdata = limit_input_mask;
         `MCI_ADDR_HOMING: next_prdata = {24'h000000, default_homing_select};
         `MCI_ADDR_CONTROL: next_prdata = ctrl;
         `MCI_ADDR_STATUS: next_prdata = {22'h000000, active_homing,
            ident_on, sync_route};
         default: next_prdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         prdata <= 32'h00000000;
      end
      else if (psel && !penable && !pwrite)
      begin
         prdata <= next_prdata;
      end
   end

endmodule : mci_core

// file: dv/mci_core_asserts.sv
// Port checker of the command and mask block.
// Assumes binding to mci_core; one clock, synchronous reset.
`timescale 1ns/1ps
module mci_core_asserts
   import mci_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pslverr,
   input wire logic drive_profile_on,
   input wire logic [7:0] stored_homing,
   input wire logic stored_valid,
   input wire logic neg_limit,
   input wire logic pos_limit,
   input wire logic [7:0] active_homing,
   input wire logic cyclic_write_on,
   input wire mci_pulse_t action,
   input wire mci_fwd_t motor_cmd
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic [31:0] last_cmd;
   logic loaded;
   wire wr_cmd = psel && penable && pwrite && paddr == 12'h008;

   function automatic mci_pulse_t pulse_of(input logic [31:0] c);
      case (c)
         32'h00000001: return 6'h20;
         32'h00000010: return 6'h10;
         32'h00000012: return 6'h08;
         32'h00000015: return 6'h04;
         32'h00000101: return 6'h02;
         32'h00000110: return 6'h01;
         default: return 6'h00;
      endcase
   endfunction : pulse_of

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         last_cmd <= 32'h00000000;
         loaded <= 1'b0;
      end
      else
      begin
         if (wr_cmd)
            last_cmd <= pwdata;
         if (stored_valid)
            loaded <= 1'b1;
      end
   end

   sequence new_cmd;
      wr_cmd && pwdata != last_cmd;
   endsequence

   AST_ACTION: assert property (new_cmd |=> action == pulse_of($past(pwdata)))
      else $error("command pulse wrong");
   AST_REPEAT: assert property (wr_cmd && pwdata == last_cmd
      |=> action == 6'h00 && !motor_cmd.valid) else $error("repeat acted");
   AST_PULSE_ONE: assert property (action != 6'h00 |=> action == 6'h00)
      else $error("pulse too long");
   AST_MOTOR_FWD: assert property (new_cmd ##0 pwdata[31:24] != 8'h00
      |=> motor_cmd.valid && motor_cmd.code == $past(pwdata))
      else $error("motor code not forwarded");
   AST_CYC_STOP: assert property (new_cmd ##0 pwdata == 32'h00000016
      |-> ##[1:2] !cyclic_write_on) else $error("cyclic writes not stopped");
   AST_PROFILE: assert property (!drive_profile_on
      |=> !neg_limit && !pos_limit) else $error("limit without profile");
   AST_SLVERR: assert property (psel && penable && !pwrite && paddr == 12'h008
      |-> pslverr) else $error("command read accepted");
   AST_HOMING: assert property (stored_valid && !loaded
      |=> active_homing == $past(stored_homing)) else $error("homing not loaded");
endmodule : mci_core_asserts

bind mci_core mci_core_asserts chk (.ref_clk, .rst, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pslverr, .drive_profile_on, .stored_homing,
   .stored_valid, .neg_limit, .pos_limit, .active_homing, .cyclic_write_on,
   .action, .motor_cmd);

// file: dv/mci_bus_master.sv
// Fieldbus master model: APB transfers into the block's registers.
// Assumes a free-running ref_clk; tasks are called from the bench.
`timescale 1ns/1ps
module mci_bus_master
(
   input wire logic ref_clk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   int timeouts = 0;
   logic [31:0] rdata;
   logic err;

   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      pstrb = 4'hF;
   end

   task automatic xfer(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
      xfer_strb(wr, a, d, 4'hF);
   endtask : xfer

   // Partial lanes matter on the merged registers and on lane 0 of homing
   task automatic xfer_strb(input logic wr, input logic [11:0] a,
      input logic [31:0] d, input logic [3:0] s);
      int i;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge ref_clk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++)
      begin
         @(posedge ref_clk);
         if (pready === 1'b1)
            break;
      end
      if (i == 16)
         timeouts++;
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer_strb

   // Zero between codes so a repeated code still executes
   task automatic command(input logic [31:0] c);
      xfer(1'b1, 12'h008, c);
      xfer(1'b1, 12'h008, 32'h00000000);
   endtask : command
endmodule : mci_bus_master

// file: dv/module_command_and_input_mask_test.sv
// Self-checking bench of the command and mask block.
// Assumes the bus master model and the bound port checker.
`timescale 1ns/1ps
module module_command_and_input_mask_test
   import mci_pkg::*;
;
   typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e;} mci_row_t;
   logic ref_clk, rst, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb, digital_input_lines;
   logic drive_profile_on, bus_sync_pulse, stored_valid, neg_limit, pos_limit;
   logic digital_output_one, power_led, cyclic_write_on;
   logic [7:0] stored_homing, active_homing;
   mci_pulse_t action;
   mci_fwd_t motor_cmd;
   logic prev_led;
   int n_errors = 0, comparisons = 0, n_pulse = 0, chg;
   mci_row_t rows [4] = '{'{12'h000, 32'hFFFFFFFF, 32'h000F0F0F},
      '{12'h004, 32'h00001234, 32'h00000034},
      '{12'h00C, 32'hA5A5A5A5, 32'hA5A5A5A5},
      '{12'h000, 32'h00000000, 32'h00000000}};
   logic [31:0] cmds [6] = '{32'h10, 32'h12, 32'h15, 32'h101, 32'h110, 32'h55};

   mci_core #(.SEC_CYCLES(10), .BLINK_CYCLES(3)) uut (.ref_clk, .rst, .psel,
      .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
      .digital_input_lines, .drive_profile_on, .bus_sync_pulse,
      .stored_homing, .stored_valid, .neg_limit, .pos_limit, .active_homing,
      .digital_output_one, .power_led, .cyclic_write_on, .action, .motor_cmd);
   mci_bus_master bm (.ref_clk, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb, .prdata, .pready, .pslverr);

   initial
   begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk)
      if (action != 6'h00)
         n_pulse++;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : settle

   task automatic close_out;
      $display("Mismatches %0d, comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : close_out

   initial
   begin
      rst = 1'b1;
      digital_input_lines = 4'h0;
      drive_profile_on = 1'b0;
      bus_sync_pulse = 1'b0;
      stored_homing = 8'h5A;
      stored_valid = 1'b0;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      stored_valid <= 1'b1;
      @(posedge ref_clk);
      // Later flash values must not reload the active method
      stored_homing <= 8'h11;
      settle(2);
      check(active_homing, 8'h5A);
      check(cyclic_write_on, 1'b1);
      foreach (rows[i])
      begin
         bm.xfer(1'b1, rows[i].a, rows[i].d);
         bm.xfer(1'b0, rows[i].a, 32'h00000000);
         check(bm.rdata, rows[i].e);
      end
      bm.xfer_strb(1'b1, 12'h000, 32'hFFFFFFFF, 4'h2);
      bm.xfer(1'b0, 12'h000, 32'h00000000);
      check(bm.rdata, 32'h00000F00);
      bm.xfer(1'b0, 12'h008, 32'h00000000);
      check(bm.err, 1'b1);
      check(bm.rdata, 32'h00000000);
      bm.xfer(1'b1, 12'h000, 32'h00010201);
      drive_profile_on <= 1'b1;
      digital_input_lines <= 4'h2;
      settle(3);
      check(neg_limit, 1'b1);
      check(pos_limit, 1'b1);
      @(posedge ref_clk);
      digital_input_lines <= 4'h1;
      settle(3);
      check({neg_limit, pos_limit}, 2'h0);
      @(posedge ref_clk);
      drive_profile_on <= 1'b0;
      digital_input_lines <= 4'h2;
      settle(3);
      check({neg_limit, pos_limit}, 2'h0);
      n_pulse = 0;
      bm.xfer(1'b1, 12'h008, 32'h00000001);
      bm.xfer(1'b1, 12'h008, 32'h00000001);
      settle(2);
      check(n_pulse, 1);
      bm.xfer(1'b1, 12'h004, 32'h00000007);
      foreach (cmds[i])
         bm.command(cmds[i]);
      bm.xfer(1'b1, 12'h008, 32'h010000E1);
      settle(2);
      check(n_pulse, 6);
      check(motor_cmd.code, 32'h010000E1);
      bm.xfer(1'b0, 12'h004, 32'h00000000);
      check(bm.rdata, 32'h00000000);
      bm.xfer(1'b0, 12'h000, 32'h00000000);
      check(bm.rdata, 32'h00000000);
      @(posedge ref_clk);
      bus_sync_pulse <= 1'b1;
      bm.command(32'h13);
      settle(2);
      check(digital_output_one, 1'b1);
      @(posedge ref_clk);
      bus_sync_pulse <= 1'b0;
      settle(2);
      check(digital_output_one, 1'b0);
      @(posedge ref_clk);
      bus_sync_pulse <= 1'b1;
      bm.command(32'h14);
      settle(2);
      check(digital_output_one, 1'b0);
      bm.command(32'h16);
      settle(2);
      check(cyclic_write_on, 1'b0);
      bm.command(32'h17);
      settle(2);
      check(cyclic_write_on, 1'b1);
      bm.command(32'h11);
      bm.xfer(1'b0, 12'h010, 32'h00000000);
      check(bm.rdata[9:1], 9'h0B5);
      // Toggle every 3 cycles: 12 cycles hold exactly 4 toggles
      chg = 0;
      #1;
      prev_led = power_led;
      repeat (12)
      begin
         @(posedge ref_clk);
         #1;
         if (power_led !== prev_led)
            chg++;
         prev_led = power_led;
      end
      check(chg, 4);
      // 120 s of 10 cycles each: still on near 1120, off after 1200
      repeat (1100) @(posedge ref_clk);
      bm.xfer(1'b0, 12'h010, 32'h00000000);
      check(bm.rdata[1], 1'b1);
      repeat (100) @(posedge ref_clk);
      bm.xfer(1'b0, 12'h010, 32'h00000000);
      check(bm.rdata[1], 1'b0);
      settle(1);
      check(power_led, 1'b1);
      bm.command(32'h16);
      check(cyclic_write_on, 1'b0);
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      settle(1);
      check(cyclic_write_on, 1'b1);
      check(active_homing, 8'h11);
      check(power_led, 1'b1);
      check(bm.timeouts, 0);
      close_out();
   end
endmodule : module_command_and_input_mask_test
